//--- rtl/tacp_pkg.sv
package tacp_pkg;

   // command byte layout
   localparam int CMD_W = 8;
   localparam int START_BIT = 7;
   localparam int CHAN_HI = 6;
   localparam int CHAN_LO = 4;
   localparam int MODE_BIT = 3;
   localparam int SER_BIT = 2;
   localparam int PDH_BIT = 1;
   localparam int PDL_BIT = 0;

   // channel bits as they sit in the partial byte at acquire start
   localparam int ACQ_CHAN_HI = 3;
   localparam int ACQ_CHAN_LO = 1;

   // receive bit counter values
   localparam logic [3:0] RX_IDLE_CNT = 4'h0;
   localparam logic [3:0] RX_FIRST_CNT = 4'h1;
   localparam logic [3:0] RX_LAST_CNT = 4'h7;
   localparam logic [3:0] ACQ_CNT = 4'h5;

   // result bits still to be shifted after the msb
   localparam int RES_W = 12;
   localparam logic [3:0] TX_LEFT12 = 4'hB;
   localparam logic [3:0] TX_LEFT8 = 4'h7;
   localparam logic [3:0] TX_END_CNT = 4'h1;
   localparam logic [3:0] TX_DONE_CNT = 4'h0;

   // channels that drive the touch panel
   localparam logic [2:0] CH_Y = 3'h1;
   localparam logic [2:0] CH_Z1 = 3'h3;
   localparam logic [2:0] CH_Z2 = 3'h4;
   localparam logic [2:0] CH_X = 3'h5;

   // reset values and buffer shape
   localparam logic [1:0] PD_RESET = 2'h0;
   localparam int BUF_DEPTH = 2;
   localparam logic [1:0] BUF_FULL = 2'h2;
   localparam logic [1:0] BUF_EMPTY = 2'h0;

   typedef enum logic [1:0] {OUT_IDLE, OUT_BUSY, OUT_SHIFT} tacp_out_e;

   // true for position and pressure channels
   function automatic logic tacp_touch_ch(input logic [2:0] ch);
      tacp_touch_ch = (ch == CH_X) || (ch == CH_Y) || (ch == CH_Z1) || (ch == CH_Z2);
   endfunction : tacp_touch_ch

endpackage : tacp_pkg

//--- rtl/tacp_stream_if.sv
`timescale 1ns/1ps
interface tacp_stream_if;
   import tacp_pkg::*;
   logic valid;
   logic ready;
   logic [RES_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : tacp_stream_if

//--- rtl/tacp_buf2.sv
`timescale 1ns/1ps
module tacp_buf2 import tacp_pkg::*; (
   input wire logic clk_sys,
   input wire logic rstn,
   tacp_stream_if.snk in_s,
   tacp_stream_if.src out_s
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic rdy_q;
   logic [RES_W-1:0] mem_q [BUF_DEPTH];
   logic [RES_W-1:0] mem_d [BUF_DEPTH];
   wire push = in_s.valid & rdy_q;
   wire pop = out_s.ready & (cnt_q != BUF_EMPTY);
   wire [1:0] wr_idx = pop ? cnt_q - 2'h1 : cnt_q;

   // handshake and occupancy
   assign in_s.ready = rdy_q;
   assign out_s.valid = (cnt_q != BUF_EMPTY);
   assign out_s.data = mem_q[0];
   assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

   // per entry: write, advance on pop (all but the last entry), or hold
   for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_ent
      localparam logic [1:0] IDX = 2'(e);
      if (e == BUF_DEPTH - 1) begin : g_last
         assign mem_d[e] = (push && wr_idx == IDX) ? in_s.data : mem_q[e];
      end else begin : g_mid
         assign mem_d[e] = (push && wr_idx == IDX) ? in_s.data :
                           pop ? mem_q[e+1] : mem_q[e];
      end
      always_ff @(posedge clk_sys) begin
         mem_q[e] <= mem_d[e];
      end
   end

   // count and registered ready
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cnt_q <= BUF_EMPTY;
         rdy_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         rdy_q <= (cnt_d != BUF_FULL);
      end
   end

   AST_BUF_NO_OVER: assert property (@(posedge clk_sys) disable iff (!rstn)
      cnt_q <= BUF_FULL) else $error("buffer count above depth");
endmodule : tacp_buf2

//--- rtl/tacp_ctl.sv
`timescale 1ns/1ps
module tacp_ctl import tacp_pkg::*; (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic serial_clock,
   input wire logic cs_n,
   input wire logic serial_in,
   input wire logic xplus_sense_n,
   input wire logic adc_valid,
   input wire logic [RES_W-1:0] adc_data,
   output logic adc_ready,
   output logic conv_start,
   output logic serial_out,
   output logic serial_out_oe_n,
   output logic busy,
   output logic busy_oe_n,
   output logic pen_touch_alert_n,
   output logic [2:0] channel_select,
   output logic reference_kind_select,
   output logic res8_select,
   output logic ref_power_on,
   output logic adc_power_on,
   output logic sample_on,
   output logic drivers_on,
   output logic ydrv_ground_on,
   output logic pen_pullup_on
);

   // synchronisers for the pins
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic sclk_d3_q;

   // command receive state
   logic [3:0] rx_cnt_q;
   logic [CMD_W-1:0] cmd_sr_q;
   logic cmd_pend_q;

   // result and power state
   tacp_out_e out_st_q;
   logic [RES_W-1:0] tx_sr_q;
   logic [3:0] tx_left_q;
   logic [1:0] pd_q;
   logic meas_q;
   logic [2:0] acq_ch_q;

   // output flops
   logic conv_start_q;
   logic serial_out_q;
   logic serial_out_oe_n_q;
   logic busy_q;
   logic busy_oe_n_q;
   logic pen_q;
   logic [2:0] channel_q;
   logic ref_kind_q;
   logic res8_q;
   logic ref_power_q;
   logic adc_power_q;
   logic sample_q;
   logic drivers_q;
   logic ydrv_q;
   logic pullup_q;

   tacp_stream_if in_if ();
   tacp_stream_if out_if ();

   // synchronised levels
   wire sclk_s = s2_q[3];
   wire csn_s = s2_q[2];
   wire din_s = s2_q[1];
   wire touch_s = s2_q[0];

   // serial clock edges, only while selected
   wire rise = sclk_s & ~sclk_d3_q & ~csn_s;
   wire fall = ~sclk_s & sclk_d3_q & ~csn_s;

   // receive decode
   wire rx_idle = (rx_cnt_q == RX_IDLE_CNT);
   wire start_det = rise & rx_idle & din_s;
   wire rx_shift = rise & ~rx_idle;
   wire rx_last = rx_shift & (rx_cnt_q == RX_LAST_CNT);
   wire acq_ev = fall & (rx_cnt_q == ACQ_CNT);

   // command fields of a finished byte, plus the channel of the partial byte at acquire
   wire [2:0] cmd_ch = cmd_sr_q[CHAN_HI:CHAN_LO];
   wire cmd_res8 = cmd_sr_q[MODE_BIT];
   wire cmd_ser = cmd_sr_q[SER_BIT];
   wire [1:0] cmd_pd = cmd_sr_q[PDH_BIT:PDL_BIT];
   wire [2:0] acq_ch = cmd_sr_q[ACQ_CHAN_HI:ACQ_CHAN_LO];

   // output sequence decode
   wire hold_ev = fall & cmd_pend_q;
   wire first_ev = fall & ~cmd_pend_q & (out_st_q == OUT_BUSY);
   wire shift_ev = fall & ~cmd_pend_q & (out_st_q == OUT_SHIFT);
   wire end_ev = shift_ev & (tx_left_q == TX_END_CNT);
   wire touch_meas = tacp_touch_ch(acq_ch_q);
   wire [RES_W-1:0] first_word = out_if.valid ? out_if.data : '0;
   wire active = meas_q | cmd_pend_q | (out_st_q != OUT_IDLE);

   // result stream from the converter core
   assign in_if.valid = adc_valid;
   assign in_if.data = adc_data;
   assign out_if.ready = first_ev;

   tacp_buf2 u_buf (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_s(in_if.snk),
      .out_s(out_if.src)
   );

   // output ports
   assign adc_ready = in_if.ready;
   assign conv_start = conv_start_q;
   assign serial_out = serial_out_q;
   assign serial_out_oe_n = serial_out_oe_n_q;
   assign busy = busy_q;
   assign busy_oe_n = busy_oe_n_q;
   assign pen_touch_alert_n = pen_q;
   assign channel_select = channel_q;
   assign reference_kind_select = ref_kind_q;
   assign res8_select = res8_q;
   assign ref_power_on = ref_power_q;
   assign adc_power_on = adc_power_q;
   assign sample_on = sample_q;
   assign drivers_on = drivers_q;
   assign ydrv_ground_on = ydrv_q;
   assign pen_pullup_on = pullup_q;

   // two-flop synchronisers plus edge history
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s1_q <= 4'hF;
         s2_q <= 4'hF;
         sclk_d3_q <= 1'b1;
      end else begin
         s1_q <= {serial_clock, cs_n, serial_in, xplus_sense_n};
         s2_q <= s1_q;
         sclk_d3_q <= sclk_s;
      end
   end

   // command shift register and bit count
   always_ff @(posedge clk_sys) begin
      if (!rstn || csn_s) begin
         rx_cnt_q <= RX_IDLE_CNT;
         cmd_sr_q <= '0;
      end else if (start_det) begin
         rx_cnt_q <= RX_FIRST_CNT;
         cmd_sr_q <= {cmd_sr_q[CMD_W-2:0], 1'b1};
      end else if (rx_shift) begin
         rx_cnt_q <= rx_last ? RX_IDLE_CNT : rx_cnt_q + 4'h1;
         cmd_sr_q <= {cmd_sr_q[CMD_W-2:0], din_s};
      end
   end

   // finished byte waits for the next falling edge
   always_ff @(posedge clk_sys) begin
      if (!rstn || csn_s) begin
         cmd_pend_q <= 1'b0;
      end else begin
         cmd_pend_q <= rx_last | (cmd_pend_q & ~fall);
      end
   end

   // acquire window: three clocks before hold
   always_ff @(posedge clk_sys) begin
      if (!rstn || csn_s) begin
         sample_q <= 1'b0;
         acq_ch_q <= '0;
      end else if (acq_ev) begin
         sample_q <= 1'b1;
         acq_ch_q <= acq_ch;
      end else if (hold_ev) begin
         sample_q <= 1'b0;
      end
   end

   // measurement in progress, ends after result bit 1
   always_ff @(posedge clk_sys) begin
      if (!rstn || csn_s) begin
         meas_q <= 1'b0;
      end else if (acq_ev) begin
         meas_q <= 1'b1;
      end else if (end_ev) begin
         meas_q <= 1'b0;
      end
   end

   // command fields taken at hold
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         channel_q <= '0;
         ref_kind_q <= 1'b0;
         res8_q <= 1'b0;
         pd_q <= PD_RESET;
         ref_power_q <= 1'b0;
      end else if (hold_ev) begin
         channel_q <= cmd_ch;
         res8_q <= cmd_res8;
         ref_kind_q <= cmd_ser;
         pd_q <= cmd_pd;
         ref_power_q <= cmd_pd[PDH_BIT];
      end
   end

   // result sequence: busy, msb, remaining bits, then low
   always_ff @(posedge clk_sys) begin
      if (!rstn || csn_s) begin
         out_st_q <= OUT_IDLE;
         busy_q <= 1'b0;
         serial_out_q <= 1'b0;
         tx_sr_q <= '0;
         tx_left_q <= TX_DONE_CNT;
      end else if (hold_ev) begin
         out_st_q <= OUT_BUSY;
         busy_q <= 1'b1;
         serial_out_q <= 1'b0;
      end else if (first_ev) begin
         out_st_q <= OUT_SHIFT;
         busy_q <= 1'b0;
         serial_out_q <= first_word[RES_W-1];
         tx_sr_q <= {first_word[RES_W-2:0], 1'b0};
         tx_left_q <= res8_q ? TX_LEFT8 : TX_LEFT12;
      end else if (shift_ev && tx_left_q == TX_DONE_CNT) begin
         out_st_q <= OUT_IDLE;
         serial_out_q <= 1'b0;
      end else if (shift_ev) begin
         serial_out_q <= tx_sr_q[RES_W-1];
         tx_sr_q <= {tx_sr_q[RES_W-2:0], 1'b0};
         tx_left_q <= tx_left_q - 4'h1;
      end
   end

   // conversion start pulse to the core
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         conv_start_q <= 1'b0;
      end else begin
         conv_start_q <= hold_ev;
      end
   end

   // pin enables follow chip select
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         serial_out_oe_n_q <= 1'b1;
         busy_oe_n_q <= 1'b1;
      end else begin
         serial_out_oe_n_q <= csn_s;
         busy_oe_n_q <= csn_s;
      end
   end

   // converter power: on while selected with low select 1 or while working
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         adc_power_q <= 1'b0;
      end else begin
         adc_power_q <= ~csn_s & (pd_q[PDL_BIT] | active);
      end
   end

   // touch drivers, Y ground and pull-up
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         drivers_q <= 1'b0;
         ydrv_q <= 1'b0;
         pullup_q <= 1'b1;
      end else begin
         drivers_q <= touch_meas & (sample_q | (meas_q & ~ref_kind_q));
         ydrv_q <= ~pd_q[PDL_BIT] & ~meas_q;
         pullup_q <= ~(meas_q & touch_meas);
      end
   end

   // pen output: forced during measurement, else sense or off
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pen_q <= 1'b1;
      end else if (meas_q) begin
         pen_q <= ~touch_meas;
      end else if (pd_q[PDL_BIT]) begin
         pen_q <= 1'b1;
      end else begin
         pen_q <= touch_s;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   AST_START_BIT: assert property (
      start_det |=> rx_cnt_q == RX_FIRST_CNT && cmd_sr_q[0])
      else $error("start bit not taken");

   AST_IGNORE_LOW: assert property (
      rise && rx_idle && !din_s |=> rx_cnt_q == RX_IDLE_CNT)
      else $error("low bit taken before start");

   AST_REF_LATCH: assert property (
      $rose(busy_q) |-> ref_power_q == $past(cmd_sr_q[PDH_BIT]))
      else $error("reference state not latched at busy");

   AST_CS_POWER_DOWN: assert property (
      csn_s && $stable(csn_s) |=> !adc_power_q && busy_oe_n_q && out_st_q == OUT_IDLE)
      else $error("select high did not power down");

   AST_REF_KEPT_CS: assert property (
      csn_s |=> $stable(ref_power_q))
      else $error("reference changed while deselected");

   AST_PEN_LOW_TOUCH: assert property (
      meas_q && touch_meas |=> !pen_q && !pullup_q)
      else $error("pen not low in position measurement");

   AST_PEN_HIGH_AUX: assert property (
      meas_q && !touch_meas |=> pen_q)
      else $error("pen not high in aux measurement");

   AST_PEN_OFF_PD0: assert property (
      !meas_q && pd_q[PDL_BIT] |=> pen_q)
      else $error("pen active with low select 1");

   AST_BUSY_ONE_CLK: assert property (
      first_ev |=> !busy_q ##0 out_st_q == OUT_SHIFT)
      else $error("busy not cleared at first bit");

   AST_RES_LEN: assert property (
      first_ev |=> tx_left_q == ($past(res8_q) ? TX_LEFT8 : TX_LEFT12))
      else $error("wrong result length");

   AST_ALWAYS_ON: assert property (
      !csn_s && pd_q == 2'h3 && !hold_ev |=> adc_power_q && ref_power_q)
      else $error("full power mode not powered");

   AST_PEN_REENABLE: assert property (
      end_ev && !pd_q[PDL_BIT] && !acq_ev |=> !meas_q ##1 pen_q == $past(touch_s))
      else $error("pen not re-enabled after bit 1");

endmodule : tacp_ctl

//--- bench/tacp_host_model.sv
`timescale 1ns/1ps
module tacp_host_model (
   input wire logic clk_sys,
   input wire logic serial_out,
   input wire logic busy,
   input wire logic pen_touch_alert_n,
   output logic serial_clock,
   output logic cs_n,
   output logic serial_in
);
   logic [11:0] res;
   logic pen_mid;
   logic busy_mid;
   logic more;
   event got;

   // link parked: clock still low, select released
   initial begin
      serial_clock = 1'b0;
      cs_n = 1'b1;
      serial_in = 1'b0;
      res = 12'h000;
      pen_mid = 1'b0;
      busy_mid = 1'b0;
      more = 1'b0;
   end

   // one framed transfer, lz leading zeros, nc commands 16 clocks apart, cut after cut clocks
   task automatic frame(input logic [7:0] cmd, input int lz, input int cut, input int nc);
      int i;
      int j;
      int k;
      res = 12'h000;
      @(negedge clk_sys);
      cs_n = 1'b0;
      // 24 clocks, 16 more per overlapped command, no pauses inside
      for (i = 1; i <= 24 + 16 * (nc - 1) + lz && i <= cut; i++) begin
         j = i - lz;
         k = (j >= 26) ? j - 16 : j;
         // next command goes in while the result comes out
         serial_in = (j >= 1 && j <= 8 + 16 * (nc - 1) && (j - 1) % 16 < 8) ?
                     cmd[7 - ((j - 1) % 16)] : 1'b0;
         repeat (4) @(negedge clk_sys);
         serial_clock = 1'b1;
         repeat (3) @(negedge clk_sys);
         // pen read as data only, never as an interrupt here
         if (j == 9) begin
            pen_mid = pen_touch_alert_n;
            busy_mid = busy;
         end
         if (k >= 10 && k <= 21) res[21 - k] = serial_out;
         @(negedge clk_sys);
         serial_clock = 1'b0;
         // hand each finished word to the checker
         if (k == 21) begin
            more = (j + 16 <= 21 + 16 * (nc - 1));
            ->got;
         end
      end
      repeat (4) @(negedge clk_sys);
      cs_n = 1'b1;
      serial_in = ~serial_in;
   endtask : frame
endmodule : tacp_host_model

//--- bench/test_touch_adc_command_power_pen_ctl.sv
`timescale 1ns/1ps
module test_touch_adc_command_power_pen_ctl;
   import tacp_pkg::*;
   logic clk_sys, rstn, serial_clock, cs_n, serial_in, xplus_sense_n, adc_valid;
   logic [RES_W-1:0] adc_data;
   logic adc_ready, conv_start, serial_out, serial_out_oe_n, busy, busy_oe_n;
   logic pen_touch_alert_n, reference_kind_select, res8_select, ref_power_on;
   logic [2:0] channel_select;
   logic adc_power_on, sample_on, drivers_on, ydrv_ground_on, pen_pullup_on;
   logic core_en, m8;
   logic tch_e, ser_e, acq_seen;
   logic [1:0] pd_e;
   logic [RES_W-1:0] exp_q[$];
   int fail_count, checked;

   tacp_ctl dut (.clk_sys, .rstn, .serial_clock, .cs_n, .serial_in, .xplus_sense_n,
      .adc_valid, .adc_data, .adc_ready, .conv_start, .serial_out, .serial_out_oe_n,
      .busy, .busy_oe_n, .pen_touch_alert_n, .channel_select, .reference_kind_select,
      .res8_select, .ref_power_on, .adc_power_on, .sample_on, .drivers_on,
      .ydrv_ground_on, .pen_pullup_on);

   tacp_host_model host (.clk_sys, .serial_out, .busy, .pen_touch_alert_n,
      .serial_clock, .cs_n, .serial_in);

   // system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
      end
   endtask : cmp_flag

   task test_done;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   // offer one word to the buffer, note what the host should see
   task automatic push(input logic [11:0] d, input logic r8);
      int k;
      @(negedge clk_sys);
      adc_valid = 1'b1;
      adc_data = d;
      for (k = 0; k < 100; k++) begin
         @(posedge clk_sys);
         if (adc_ready === 1'b1) break;
      end
      cmp_flag(adc_ready, 1'b1);
      exp_q.push_back(r8 ? d & 12'hFF0 : d);
      @(negedge clk_sys);
      adc_valid = 1'b0;
      adc_data = ~d;
   endtask : push

   // converter core model answers each hold pulse while core_en is set, touch switches checked first
   always @(posedge clk_sys) begin
      if (sample_on === 1'b1) acq_seen = 1'b1;
      if (core_en && conv_start === 1'b1) begin
         cmp_flag(acq_seen, 1'b1);
         cmp_flag(sample_on, 1'b0);
         acq_seen = 1'b0;
         repeat (2) @(negedge clk_sys);
         cmp_flag(drivers_on, tch_e & !ser_e);
         cmp_flag(pen_pullup_on, !tch_e);
         push(12'($urandom % 4096), m8);
      end
   end

   // result checker takes the oldest note per received word
   always @(host.got) begin
      cmp_word(host.res, exp_q.size() > 0 ? exp_q.pop_front() : 12'hFFF);
      // converter power between conversions while still selected
      if (!host.more) begin
         repeat (6) @(negedge clk_sys);
         cmp_flag(adc_power_on, pd_e[0]);
      end
   end

   // one full conversion and the state it leaves behind
   task automatic conv(input logic [2:0] ch, input logic r8, input logic [1:0] pd, input int nc);
      logic s;
      logic xs;
      logic tch;
      tch = ch inside {3'h1, 3'h3, 3'h4, 3'h5};
      s = tch ? 1'($urandom % 2) : 1'b1;
      xs = 1'($urandom % 2);
      xplus_sense_n = xs;
      m8 = r8;
      tch_e = tch;
      ser_e = s;
      pd_e = pd;
      host.frame({1'b1, ch, r8, s, pd}, $urandom % 3, 99, nc);
      repeat (8) @(negedge clk_sys);
      cmp_flag(host.busy_mid, 1'b1);
      cmp_flag(host.pen_mid, !tch);
      cmp_word(12'(channel_select), 12'(ch));
      cmp_flag(res8_select, r8);
      cmp_flag(reference_kind_select, s);
      cmp_flag(ref_power_on, pd[1]);
      cmp_flag(ydrv_ground_on, !pd[0]);
      cmp_flag(pen_touch_alert_n, pd[0] | xs);
      cmp_flag(adc_power_on, 1'b0);
      cmp_flag(serial_out_oe_n, 1'b1);
   endtask : conv

   // watchdog
   initial begin
      #300us;
      fail_count++;
      $display("[FAIL] %0t run did not finish", $time);
      test_done;
   end

   // main sequence
   initial begin
      int n;
      rstn = 1'b0;
      xplus_sense_n = 1'b1;
      adc_valid = 1'b0;
      adc_data = 12'h000;
      core_en = 1'b1;
      m8 = 1'b0;
      tch_e = 1'b0;
      ser_e = 1'b0;
      acq_seen = 1'b0;
      pd_e = 2'h0;
      fail_count = 0;
      checked = 0;
      void'($urandom(78404));
      repeat (6) @(negedge clk_sys);
      cmp_flag(busy_oe_n, 1'b1);
      cmp_flag(pen_touch_alert_n, 1'b1);
      cmp_flag(adc_ready, 1'b1);
      rstn = 1'b1;
      repeat (6) @(negedge clk_sys);
      // every power select, 12 then 8 bit, odd ones overlapped at 16 clocks
      for (n = 0; n < 8; n++) conv(3'($urandom % 8), 1'(n / 4), 2'(n), 1 + n % 2);
      // select dropped before hold: reference stays as latched
      host.frame(8'h90, 0, 5, 1);
      repeat (8) @(negedge clk_sys);
      cmp_flag(ref_power_on, 1'b1);
      cmp_flag(busy_oe_n, 1'b1);
      cmp_flag(adc_power_on, 1'b0);
      // fill the buffer until it refuses, then drain by the host
      core_en = 1'b0;
      push(12'($urandom % 4096), 1'b0);
      push(12'($urandom % 4096), 1'b0);
      repeat (2) @(negedge clk_sys);
      cmp_flag(adc_ready, 1'b0);
      conv(3'h0, 1'b0, 2'h3, 1);
      conv(3'h2, 1'b0, 2'h0, 1);
      cmp_flag(adc_ready, 1'b1);
      repeat (20) @(negedge clk_sys);
      // every noted result was delivered
      cmp_word(12'(exp_q.size()), 12'h000);
      test_done;
   end
endmodule : test_touch_adc_command_power_pen_ctl
